// [rtl/hv_ctrl_defs.svh]
// Offsets, field positions, reset values and timing counts of the HV control.
`ifndef HV_CTRL_DEFS_SVH
`define HV_CTRL_DEFS_SVH

`define OFS_PULSE_TIMING   4'h0
`define OFS_BLOCK_SELECT   4'h2
`define ADDR_W             4

`define PTC_MULT_LSB       0
`define PTC_MULT_W         7
`define PTC_RESET          7'h00

`define BSC_BLOCK_LSB      8
`define BSC_GEM_BIT        5
`define BSC_B0M_BIT        4
`define BSC_PES_BIT        2
`define BSC_SSL_BIT        1
`define BSC_PEN_BIT        0
`define BSC_RESET          16'h0000

`define BASE_PERIOD_NS     1000
`define CLK_PERIOD_NS      8
`define BASE_CYCLES        ((`BASE_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BASE_CNT_W         8

`endif

// [rtl/hv_ctrl_pkg.sv]
// Types shared by the HV control modules.
package hv_ctrl_pkg;
  typedef enum logic [1:0] {PULSE_IDLE, PULSE_RUN, PULSE_DONE} pulse_state_e;
  typedef logic [7:0] block_mask_t;
endpackage

// [rtl/hv_filter_if.sv]
// Raw and filtered enable pin levels passed between the filter and the core.
`timescale 1ns/1ps
`default_nettype none
interface hv_filter_if;
  logic [1:0] rawPin;
  logic [1:0] filtered;
  modport filt (input rawPin, output filtered);
  modport core (output rawPin, input filtered);
endinterface
`default_nettype wire

// [rtl/hv_enable_filter.sv]
// Two-sample agreement filters for the enable inputs.
`timescale 1ns/1ps
`default_nettype none
module hv_enable_filter (
  input  wire logic clk,
  input  wire logic arst_n,
  hv_filter_if.filt flt
);
  logic [1:0] lastSample;
  logic [1:0] outLevel;
  logic [1:0] next_lastSample;
  logic [1:0] next_outLevel;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gFilt
      always_comb begin
        next_lastSample[g] = flt.rawPin[g];
        // The output moves only once two samples in a row agree.
        next_outLevel[g] = (flt.rawPin[g] == lastSample[g]) ?
                           lastSample[g] : outLevel[g]; // R8 R9
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lastSample <= 2'h0;
      outLevel   <= 2'h0;
    end else begin
      lastSample <= next_lastSample;
      outLevel   <= next_outLevel;
    end
  end

  assign flt.filtered = outLevel;

  property p_filt_agree;
    @(posedge clk) disable iff (!arst_n)
      (flt.rawPin[0] != $past(flt.rawPin[0])) |=> $stable(outLevel[0]);
  endproperty
  a_filt_agree: assert property (p_filt_agree) // R8
    else $error("global filter changed after one sample");

  property p_filt_b0;
    @(posedge clk) disable iff (!arst_n)
      (flt.rawPin[1] != $past(flt.rawPin[1])) |=> $stable(outLevel[1]);
  endproperty
  a_filt_b0: assert property (p_filt_b0) // R9
    else $error("block zero filter changed after one sample");
endmodule
`default_nettype wire

// [rtl/hv_pulse_timer.sv]
// Linear pulse stretcher: counts one plus multiplier base periods.
`timescale 1ns/1ps
`default_nettype none
`include "hv_ctrl_defs.svh"
module hv_pulse_timer
  import hv_ctrl_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire logic                   start,
  input  wire logic                   abort,
  input  wire logic [`PTC_MULT_W-1:0] mult,
  output logic                        active,
  output logic                        done
);
  localparam int BaseCycles = `BASE_CYCLES;
  localparam logic [`BASE_CNT_W-1:0] BaseLast =
    `BASE_CNT_W'(BaseCycles - 1);

  pulse_state_e               state;
  pulse_state_e               next_state;
  logic [`BASE_CNT_W-1:0]     baseCnt;
  logic [`BASE_CNT_W-1:0]     next_baseCnt;
  logic [`PTC_MULT_W-1:0]     periodCnt;
  logic [`PTC_MULT_W-1:0]     next_periodCnt;

  always_comb begin
    next_state     = state;
    next_baseCnt   = baseCnt;
    next_periodCnt = periodCnt;
    unique case (state)
      PULSE_IDLE: begin
        if (start) begin
          next_state     = PULSE_RUN;
          next_baseCnt   = '0;
          next_periodCnt = mult; // R2
        end
      end
      PULSE_RUN: begin
        if (abort) begin
          next_state = PULSE_IDLE;
        end else if (baseCnt == BaseLast) begin
          next_baseCnt = '0;
          // Runs mult+1 base periods, so 1 to 128 in all.
          if (periodCnt == '0) begin
            next_state = PULSE_DONE; // R2
          end else begin
            next_periodCnt = periodCnt - 1'b1;
          end
        end else begin
          next_baseCnt = baseCnt + 1'b1;
        end
      end
      PULSE_DONE: begin
        if (abort) begin
          next_state = PULSE_IDLE;
        end
      end
      default: next_state = PULSE_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= PULSE_IDLE;
      baseCnt   <= '0;
      periodCnt <= '0;
    end else begin
      state     <= next_state;
      baseCnt   <= next_baseCnt;
      periodCnt <= next_periodCnt;
    end
  end

  assign active = (state == PULSE_RUN);
  assign done   = (state == PULSE_DONE);

  property p_period_step;
    @(posedge clk) disable iff (!arst_n)
      (active && !abort && baseCnt == BaseLast && periodCnt != '0)
        |=> (periodCnt == $past(periodCnt) - 1'b1);
  endproperty
  a_period_step: assert property (p_period_step) // R2
    else $error("period counter did not step down");
endmodule
`default_nettype wire

// [rtl/hv_pulse_block_ctrl.sv]
// High-voltage pulse timing, block select and enable monitor registers.
//
// Notes on behaviour
// R1: Multiplier writes ignored while sequence locked.
// R2: Pulse lasts one plus multiplier base periods.
// R3: Block mask writes ignored while sequence locked.
// R4: Every masked block gets the operation together.
// R5: Software selects only blocks being programmed.
// R6: Global enable captured at pulse-enable rise, held.
// R7: Global monitor one means high voltage possible.
// R8: Enable input filtered over two agreeing samples.
// R9: Block zero monitor captured, filtered likewise.
// R10: Block zero gated by captured block monitor.
// R11: High voltage needs pulse-enable and global monitor.
// R12: Lock bit writes ignored during pulse or status.
// R13: Reserved bits read zero; reserved and monitor bits ignore writes.
`timescale 1ns/1ps
`default_nettype none
`include "hv_ctrl_defs.svh"
module hv_pulse_block_ctrl
  import hv_ctrl_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire logic [`ADDR_W-1:0]   regAddr,
  input  wire logic [15:0]          regWdata,
  input  wire logic                 regWrite,
  input  wire logic                 regRead,
  output logic      [15:0]          regRdata,
  input  wire logic                 progEraseEnableInput,
  input  wire logic                 blockZeroEnableInput,
  output logic                      hvActive,
  output logic      [7:0]           blockHvEnable,
  output logic                      programOrEraseSelect,
  output logic                      pulseDone
);
  // ---------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------
  logic [`PTC_MULT_W-1:0] pulseLinearMultiplier;
  logic [`PTC_MULT_W-1:0] next_pulseLinearMultiplier;
  block_mask_t            blockMask;
  block_mask_t            next_blockMask;
  logic                   progOrErase;
  logic                   next_progOrErase;
  logic                   sequenceStartLock;
  logic                   next_sequenceStartLock;
  logic                   pulseEnable;
  logic                   next_pulseEnable;
  logic                   globalEnableMonitor;
  logic                   next_globalEnableMonitor;
  logic                   blockZeroEnableMonitor;
  logic                   next_blockZeroEnableMonitor;
  logic [15:0]            next_regRdata;
  logic                   highVoltageStatus;
  logic                   timerActive;
  logic                   timerDone;

  function automatic logic hit(input logic [`ADDR_W-1:0] a,
                               input logic [`ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  logic wrTiming;
  logic wrBlock;
  assign wrTiming = regWrite && hit(regAddr, `OFS_PULSE_TIMING);
  assign wrBlock  = regWrite && hit(regAddr, `OFS_BLOCK_SELECT);

  // ---------------------------------------------------------------------
  // Enable filters and pulse timer
  // ---------------------------------------------------------------------
  hv_filter_if filtBus ();
  assign filtBus.rawPin = {blockZeroEnableInput, progEraseEnableInput};

  hv_enable_filter hv_enable_filter_i (
    .clk    (clk),
    .arst_n (arst_n),
    .flt    (filtBus)
  );

  hv_pulse_timer hv_pulse_timer_i (
    .clk    (clk),
    .arst_n (arst_n),
    .start  (pulseEnable && globalEnableMonitor && !timerActive
             && !timerDone),
    .abort  (!pulseEnable),
    .mult   (pulseLinearMultiplier),
    .active (timerActive),
    .done   (timerDone)
  );

  // Status stays high for the running pulse only; no recovery time is added.
  assign highVoltageStatus = timerActive;

  // ---------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------
  always_comb begin
    next_pulseLinearMultiplier  = pulseLinearMultiplier;
    next_blockMask              = blockMask;
    next_progOrErase            = progOrErase;
    next_sequenceStartLock      = sequenceStartLock;
    next_pulseEnable            = pulseEnable;
    next_globalEnableMonitor    = globalEnableMonitor;
    next_blockZeroEnableMonitor = blockZeroEnableMonitor;

    if (wrTiming && !sequenceStartLock) begin
      next_pulseLinearMultiplier =
        regWdata[`PTC_MULT_LSB +: `PTC_MULT_W]; // R1
    end
    if (wrBlock) begin
      if (!sequenceStartLock) begin
        next_blockMask   = regWdata[`BSC_BLOCK_LSB +: 8]; // R3
        next_progOrErase = regWdata[`BSC_PES_BIT];
      end
      if (!highVoltageStatus && !pulseEnable) begin
        next_sequenceStartLock = regWdata[`BSC_SSL_BIT]; // R12
      end
      // Pulse-enable only sets inside a locked sequence; clearing always works.
      next_pulseEnable = regWdata[`BSC_PEN_BIT] && sequenceStartLock;
    end
    // Monitors track the filter while idle and freeze on the pulse-enable rise.
    if (!pulseEnable) begin
      next_globalEnableMonitor    = filtBus.filtered[0]; // R6
      next_blockZeroEnableMonitor = filtBus.filtered[1]; // R9
    end

    next_regRdata = 16'h0000;
    if (regRead) begin
      unique case (regAddr)
        `OFS_PULSE_TIMING: begin
          next_regRdata[15] = highVoltageStatus;
          next_regRdata[`PTC_MULT_LSB +: `PTC_MULT_W] =
            pulseLinearMultiplier; // R13
        end
        `OFS_BLOCK_SELECT: begin
          next_regRdata[`BSC_BLOCK_LSB +: 8] = blockMask;
          next_regRdata[`BSC_GEM_BIT] = globalEnableMonitor; // R7
          next_regRdata[`BSC_B0M_BIT] = blockZeroEnableMonitor;
          next_regRdata[`BSC_PES_BIT] = progOrErase;
          next_regRdata[`BSC_SSL_BIT] = sequenceStartLock;
          next_regRdata[`BSC_PEN_BIT] = pulseEnable; // R13
        end
        default: next_regRdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pulseLinearMultiplier  <= `PTC_RESET;
      blockMask              <= block_mask_t'(`BSC_RESET >> `BSC_BLOCK_LSB);
      progOrErase            <= 1'b0;
      sequenceStartLock      <= 1'b0;
      pulseEnable            <= 1'b0;
      globalEnableMonitor    <= 1'b0;
      blockZeroEnableMonitor <= 1'b0;
      regRdata               <= 16'h0000;
    end else begin
      pulseLinearMultiplier  <= next_pulseLinearMultiplier;
      blockMask              <= next_blockMask;
      progOrErase            <= next_progOrErase;
      sequenceStartLock      <= next_sequenceStartLock;
      pulseEnable            <= next_pulseEnable;
      globalEnableMonitor    <= next_globalEnableMonitor;
      blockZeroEnableMonitor <= next_blockZeroEnableMonitor;
      regRdata               <= next_regRdata;
    end
  end

  // ---------------------------------------------------------------------
  // High-voltage outputs
  // ---------------------------------------------------------------------
  // Mask bits only route the pulse; software must select real targets.
  // The timer aborts one edge late, so pulse-enable gates the output itself.
  assign hvActive = timerActive && pulseEnable && globalEnableMonitor; // R11
  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : gBlk
      if (b == 0) begin : gZero
        assign blockHvEnable[b] =
          hvActive && blockMask[b] && blockZeroEnableMonitor; // R10
      end else begin : gOther
        assign blockHvEnable[b] = hvActive && blockMask[b]; // R4
      end
    end
  endgenerate
  assign programOrEraseSelect = progOrErase;
  assign pulseDone            = timerDone;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  property p_mult_lock;
    @(posedge clk) disable iff (!arst_n)
      (wrTiming && sequenceStartLock) |=> $stable(pulseLinearMultiplier);
  endproperty
  a_mult_lock: assert property (p_mult_lock) // R1
    else $error("multiplier changed while locked");

  property p_mask_lock;
    @(posedge clk) disable iff (!arst_n)
      (wrBlock && sequenceStartLock) |=> $stable(blockMask);
  endproperty
  a_mask_lock: assert property (p_mask_lock) // R3
    else $error("block mask changed while locked");

  property p_lock_hold;
    @(posedge clk) disable iff (!arst_n)
      (wrBlock && (pulseEnable || highVoltageStatus))
        |=> $stable(sequenceStartLock);
  endproperty
  a_lock_hold: assert property (p_lock_hold) // R12
    else $error("lock bit changed during pulse");

  property p_monitor_hold;
    @(posedge clk) disable iff (!arst_n)
      (pulseEnable && $past(pulseEnable))
        |-> $stable(globalEnableMonitor) && $stable(blockZeroEnableMonitor);
  endproperty
  a_monitor_hold: assert property (p_monitor_hold) // R6
    else $error("monitor moved while pulse enabled");

  property p_hv_gate;
    @(posedge clk) disable iff (!arst_n)
      hvActive |-> pulseEnable && globalEnableMonitor;
  endproperty
  a_hv_gate: assert property (p_hv_gate) // R11
    else $error("high voltage without both enables");

  property p_block_zero;
    @(posedge clk) disable iff (!arst_n)
      !blockZeroEnableMonitor |-> !blockHvEnable[0];
  endproperty
  a_block_zero: assert property (p_block_zero) // R10
    else $error("block zero driven while disabled");

  property p_blocks;
    @(posedge clk) disable iff (!arst_n)
      hvActive |-> (blockHvEnable[7:1] == blockMask[7:1]);
  endproperty
  a_blocks: assert property (p_blocks) // R4
    else $error("selected blocks not driven together");

  property p_read_zero;
    @(posedge clk) disable iff (!arst_n)
      (regRead && hit(regAddr, `OFS_BLOCK_SELECT))
        |=> (regRdata[7:6] == 2'h0) && !regRdata[3];
  endproperty
  a_read_zero: assert property (p_read_zero) // R13
    else $error("reserved bits read non-zero");

  property p_monitor_read;
    @(posedge clk) disable iff (!arst_n)
      (regRead && hit(regAddr, `OFS_BLOCK_SELECT))
        |=> regRdata[`BSC_GEM_BIT] == $past(globalEnableMonitor);
  endproperty
  a_monitor_read: assert property (p_monitor_read) // R7
    else $error("global monitor read wrong");

  property p_mult_write;
    @(posedge clk) disable iff (!arst_n)
      (wrTiming && !sequenceStartLock)
        |=> (pulseLinearMultiplier ==
             $past(regWdata[`PTC_MULT_LSB +: `PTC_MULT_W]));
  endproperty
  a_mult_write: assert property (p_mult_write) // R1
    else $error("multiplier write was lost");

  property p_mask_write;
    @(posedge clk) disable iff (!arst_n)
      (wrBlock && !sequenceStartLock)
        |=> (blockMask == $past(regWdata[`BSC_BLOCK_LSB +: 8]));
  endproperty
  a_mask_write: assert property (p_mask_write) // R3
    else $error("block mask write was lost");

  property p_lock_write;
    @(posedge clk) disable iff (!arst_n)
      (wrBlock && !pulseEnable && !highVoltageStatus)
        |=> (sequenceStartLock == $past(regWdata[`BSC_SSL_BIT]));
  endproperty
  a_lock_write: assert property (p_lock_write) // R12
    else $error("lock bit write was lost");

  property p_capture_global;
    @(posedge clk) disable iff (!arst_n)
      $rose(pulseEnable)
        |-> (globalEnableMonitor == $past(filtBus.filtered[0]));
  endproperty
  a_capture_global: assert property (p_capture_global) // R6
    else $error("global monitor not captured at pulse start");

  property p_capture_b0;
    @(posedge clk) disable iff (!arst_n)
      $rose(pulseEnable)
        |-> (blockZeroEnableMonitor == $past(filtBus.filtered[1]));
  endproperty
  a_capture_b0: assert property (p_capture_b0) // R9
    else $error("block zero monitor not captured at pulse start");

  property p_b0_read;
    @(posedge clk) disable iff (!arst_n)
      (regRead && hit(regAddr, `OFS_BLOCK_SELECT))
        |=> regRdata[`BSC_B0M_BIT] == $past(blockZeroEnableMonitor);
  endproperty
  a_b0_read: assert property (p_b0_read) // R9
    else $error("block zero monitor read wrong");

  property p_timing_read;
    @(posedge clk) disable iff (!arst_n)
      (regRead && hit(regAddr, `OFS_PULSE_TIMING))
        |=> (regRdata[15] == $past(highVoltageStatus))
            && (regRdata[14:7] == 8'h00);
  endproperty
  a_timing_read: assert property (p_timing_read) // R13
    else $error("timing register read wrong");

  property p_mult_read;
    @(posedge clk) disable iff (!arst_n)
      (regRead && hit(regAddr, `OFS_PULSE_TIMING))
        |=> (regRdata[`PTC_MULT_LSB +: `PTC_MULT_W]
             == $past(pulseLinearMultiplier));
  endproperty
  a_mult_read: assert property (p_mult_read) // R1
    else $error("multiplier read wrong");

  property p_idle_read;
    @(posedge clk) disable iff (!arst_n)
      !(regRead && (hit(regAddr, `OFS_PULSE_TIMING)
                    || hit(regAddr, `OFS_BLOCK_SELECT)))
        |=> (regRdata == 16'h0000);
  endproperty
  a_idle_read: assert property (p_idle_read) // R13
    else $error("read data not zero outside a read");

  property p_abort;
    @(posedge clk) disable iff (!arst_n)
      !pulseEnable |=> !highVoltageStatus;
  endproperty
  a_abort: assert property (p_abort) // R11
    else $error("pulse kept running after pulse-enable cleared");

  property p_blocks_off;
    @(posedge clk) disable iff (!arst_n)
      !hvActive |-> (blockHvEnable == 8'h00);
  endproperty
  a_blocks_off: assert property (p_blocks_off) // R11
    else $error("block enabled without high voltage");

  property p_mask_idle;
    @(posedge clk) disable iff (!arst_n)
      !wrBlock |=> $stable(blockMask) && $stable(progOrErase);
  endproperty
  a_mask_idle: assert property (p_mask_idle) // R3
    else $error("block mask moved without a write");
endmodule
`default_nettype wire

// [verif/test_hv_pulse_block_ctrl.sv]
// Self-checking bench for the HV pulse timing and block select registers.
`timescale 1ns/1ps
`default_nettype none
`include "hv_ctrl_defs.svh"
module test_hv_pulse_block_ctrl;
  // ----------------------------------------------------------------------
  // Signals and instance
  // ----------------------------------------------------------------------
  localparam int LIMIT = 5000;
  logic                 clk;
  logic                 arst_n;
  logic [`ADDR_W-1:0]   regAddr;
  logic [15:0]          regWdata;
  logic                 regWrite;
  logic                 regRead;
  logic [15:0]          regRdata;
  logic                 progEraseEnableInput;
  logic                 blockZeroEnableInput;
  logic                 hvActive;
  logic [7:0]           blockHvEnable;
  logic                 programOrEraseSelect;
  logic                 pulseDone;
  int                   n_fail;
  int                   n_compared;
  int                   cycles;
  int                   activeCnt;

  hv_pulse_block_ctrl hv_pulse_block_ctrl_i (
    .clk                  (clk),
    .arst_n               (arst_n),
    .regAddr              (regAddr),
    .regWdata             (regWdata),
    .regWrite             (regWrite),
    .regRead              (regRead),
    .regRdata             (regRdata),
    .progEraseEnableInput (progEraseEnableInput),
    .blockZeroEnableInput (blockZeroEnableInput),
    .hvActive             (hvActive),
    .blockHvEnable        (blockHvEnable),
    .programOrEraseSelect (programOrEraseSelect),
    .pulseDone            (pulseDone)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // A hung wait ends here rather than running the simulator forever.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_fail++;
      test_done();
    end
  end

  always @(negedge clk) begin
    if (hvActive === 1'b1) begin
      activeCnt <= activeCnt + 1;
    end
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs();
    logic [15:0] v;
    rd(4'h0, v); chk(v, 16'h0000);
    rd(4'h2, v); chk(v, 16'h0000);
    rd(4'h5, v); chk(v, 16'h0000);
    @(posedge clk);
    #1 chk(regRdata, 16'h0000);
    wr(4'h2, 16'h0001);
    rd(4'h2, v); chk(v, 16'h0000);
    wr(4'h0, 16'hffff);
    rd(4'h0, v); chk(v, 16'h007f);
    wr(4'h2, 16'hffff);
    rd(4'h2, v); chk(v, 16'hff06);
    chk({15'h0, programOrEraseSelect}, 16'h0001);
    wr(4'h0, 16'h0005);
    rd(4'h0, v); chk(v, 16'h007f);
    // Lock is released here but mask and select still see it set.
    wr(4'h2, 16'h0000);
    rd(4'h2, v); chk(v, 16'hff04);
    wr(4'h0, 16'h0000);
    rd(4'h0, v); chk(v, 16'h0000);
    wr(4'h2, 16'h0000);
    rd(4'h2, v); chk(v, 16'h0000);
    chk({15'h0, programOrEraseSelect}, 16'h0000);
  endtask

  task automatic t_filter();
    logic [15:0] v;
    @(posedge clk);
    progEraseEnableInput <= 1'b1;
    blockZeroEnableInput <= 1'b1;
    @(posedge clk);
    progEraseEnableInput <= 1'b0;
    blockZeroEnableInput <= 1'b0;
    repeat (4) @(posedge clk);
    rd(4'h2, v); chk(v & 16'h0030, 16'h0000);
    @(posedge clk);
    progEraseEnableInput <= 1'b1;
    blockZeroEnableInput <= 1'b1;
    repeat (4) @(posedge clk);
    rd(4'h2, v); chk(v & 16'h0030, 16'h0030);
  endtask

  task automatic run_pulse(input logic [6:0] m, input logic [7:0] mask,
                           input logic glob, input logic b0);
    logic [15:0] v;
    logic [15:0] mon;
    int          n;
    mon = {10'h0, glob, b0, 4'h0};
    @(posedge clk);
    progEraseEnableInput <= glob;
    blockZeroEnableInput <= b0;
    repeat (5) @(posedge clk);
    wr(4'h0, {9'h0, m});
    wr(4'h2, {mask, 8'h02});
    activeCnt = 0;
    wr(4'h2, {mask, 8'h03});
    for (n = 0; n < 6 && hvActive !== glob; n++) begin
      @(negedge clk);
    end
    chk({15'h0, hvActive}, {15'h0, glob});
    chk({8'h0, blockHvEnable},
        glob ? {8'h0, mask[7:1], mask[0] & b0} : 16'h0000);
    // Inputs flip mid-pulse; the captured monitors must not follow.
    @(posedge clk);
    progEraseEnableInput <= ~glob;
    blockZeroEnableInput <= ~b0;
    repeat (4) @(posedge clk);
    rd(4'h2, v); chk(v, {mask, 8'h03} | mon);
    rd(4'h0, v); chk(v, {glob, 8'h0, m});
    wr(4'h2, {mask, 8'h01});
    for (n = 0; n < 17000 && hvActive === 1'b1; n++) begin
      @(negedge clk);
    end
    @(negedge clk);
    chk(activeCnt[15:0],
        glob ? 16'(`BASE_CYCLES * (m + 1)) : 16'h0000);
    chk({15'h0, pulseDone}, {15'h0, glob});
    rd(4'h2, v); chk(v, {mask, 8'h03} | mon);
    wr(4'h2, {mask, 8'h02});
    // Done drops only once the timer has seen pulse-enable low.
    @(posedge clk);
    @(negedge clk);
    chk({15'h0, pulseDone}, 16'h0000);
    wr(4'h2, 16'h0000);
    repeat (4) @(posedge clk);
    rd(4'h2, v); chk(v, {mask, 2'b00, ~glob, ~b0, 4'h0});
    wr(4'h2, 16'h0000);
    rd(4'h2, v); chk(v, 16'h0000 | {10'h0, ~glob, ~b0, 4'h0});
  endtask

  // Pulse-enable cleared mid-pulse must cut high voltage at once.
  task automatic t_abort();
    logic [15:0] v;
    wr(4'h0, 16'h0010);
    wr(4'h2, 16'h0302);
    wr(4'h2, 16'h0303);
    repeat (3) @(negedge clk);
    chk({15'h0, hvActive}, 16'h0001);
    chk({8'h0, blockHvEnable}, 16'h0002);
    wr(4'h2, 16'h0302);
    @(negedge clk);
    chk({15'h0, hvActive}, 16'h0000);
    chk({8'h0, blockHvEnable}, 16'h0000);
    @(negedge clk);
    chk({15'h0, pulseDone}, 16'h0000);
    rd(4'h0, v);
    chk(v, 16'h0010);
    wr(4'h2, 16'h0000);
    wr(4'h2, 16'h0000);
    rd(4'h2, v);
    chk(v, 16'h0020);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    arst_n               = 1'b0;
    regAddr              = 4'h0;
    regWdata             = 16'h0000;
    regWrite             = 1'b0;
    regRead              = 1'b0;
    progEraseEnableInput = 1'b0;
    blockZeroEnableInput = 1'b0;
    n_fail               = 0;
    n_compared           = 0;
    cycles               = 0;
    activeCnt            = 0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    t_regs();
    t_filter();
    run_pulse(7'h00, 8'h03, 1'b1, 1'b1);
    run_pulse(7'h02, 8'h81, 1'b1, 1'b0);
    run_pulse(7'h01, 8'hff, 1'b0, 1'b1);
    t_abort();
    test_done();
  end
endmodule
`default_nettype wire
